// *** logic/sps_sequencer.sv ***
module sps_sequencer
  import sps_pkg::*;
#(
  parameter logic [CNT_W-1:0] SEQ_DLY_CYC = CNT_W'(SEQ_DLY_DEF),
  parameter logic [CNT_W-1:0] PG_LIM_CYC = CNT_W'(PG_LIM_DEF),
  parameter logic [CNT_W-1:0] RST_DLY_CYC = CNT_W'(RST_DLY_DEF)
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Supply comparator inputs
  input wire logic seq_request,
  input wire logic [NCH-1:0] uv_below,
  input wire logic [NCH-1:0] up_above,
  input wire logic [NCH-1:0] down_below,
  // Supply outputs
  output logic [NCH-1:0] supply_enable,
  output logic [NCH-1:0] channel_compare_flag,
  output logic reset_out_n,
  // Shared open-drain fault and done lines, master-driven cascade line
  input wire logic fault_line_n_in,
  output logic fault_line_n_out,
  output logic fault_line_n_oe,
  output logic done_n_out,
  output logic done_n_oe,
  input wire logic cascade_in,
  output logic cascade_out,
  output logic cascade_oe
);
  sps_sense_type raw, sense;
  sps_state_type state;
  sps_ftype_type ftype;
  sps_cfg_type cfg;
  logic [TPOS_W-1:0] time_position_select;
  logic [CNT_W-1:0] seq_dly, pg_lim, rst_dly;
  logic [POS_W-1:0] pos;
  logic req_prev, cas_prev, req_rise, req_fall, cas_fall;
  logic dly_active, waiting, first_step, pg_active, rst_released;
  logic seq_exp, pg_exp, rst_exp, delay_done, in_seq, all_good;
  logic cmd_fault, seq_fault, ext_fault, rst_fault, int_fault, fault_now;
  logic [NCH-1:0] at_pos, next_flags;
  logic [1:0] own_pull;

  function automatic logic [NCH-1:0] chan_at(
    input logic [TPOS_W-1:0] tp, input logic [POS_W-1:0] p);
    logic [NCH-1:0] m;
    m = '0;
    for (int i = 0; i < NCH; i++) begin
      m[i] = (tp[i*POS_W +: POS_W] == p);
    end
    return m;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == OFF_CTRL || a == OFF_TPOS || a == OFF_SEQ_DLY ||
      a == OFF_PG_LIM || a == OFF_RST_DLY || a == OFF_STATUS ||
      a == OFF_FLAGS;
  endfunction

  // Pins are asynchronous to pclk
  assign raw = '{seq_request: seq_request, fault_line_n: fault_line_n_in,
                 cascade: cascade_in, uv_below: uv_below,
                 up_above: up_above, down_below: down_below};

  sps_sync #(.W(SENSE_W)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(raw),
    .q(sense)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_prev <= 1'b0;
      cas_prev <= 1'b0;
      own_pull <= '0;
    end else begin
      req_prev <= sense.seq_request;
      cas_prev <= sense.cascade;
      own_pull <= {own_pull[0], fault_line_n_oe};
    end
  end

  assign req_rise = sense.seq_request && !req_prev;
  assign req_fall = !sense.seq_request && req_prev;
  assign cas_fall = !sense.cascade && cas_prev;
  assign in_seq = (state == ST_SEQ_UP) || (state == ST_SEQ_DOWN);
  assign at_pos = chan_at(time_position_select, pos);
  assign all_good = !(|sense.uv_below);

  // Slaves are paced by the master's cascade pulse
  assign delay_done = dly_active && ((first_step && !cfg.first) ||
    (cfg.master ? seq_exp : cas_fall));

  sps_timer u_seq_timer (
    .pclk(pclk),
    .presetn(presetn),
    .clear(!dly_active),
    .run(dly_active),
    .limit(seq_dly),
    .expired(seq_exp)
  );

  sps_timer u_pg_timer (
    .pclk(pclk),
    .presetn(presetn),
    .clear(!pg_active),
    .run(pg_active),
    .limit(pg_lim),
    .expired(pg_exp)
  );

  sps_timer u_rst_timer (
    .pclk(pclk),
    .presetn(presetn),
    .clear(!all_good),
    .run(all_good),
    .limit(rst_dly),
    .expired(rst_exp)
  );

  assign cmd_fault = in_seq && (req_rise || req_fall);
  // A zero limit disables the power-good watchdog
  assign seq_fault = in_seq && pg_active && pg_exp && pg_lim != '0;
  // Only a low that we are not causing ourselves counts; our own release
  // needs two synchroniser edges to show, so a low is masked that long
  assign ext_fault = !sense.fault_line_n && !fault_line_n_oe &&
    own_pull == '0 && state != ST_FAULTED;
  assign rst_fault = cfg.rst_fault && rst_released && reset_out_n &&
    !all_good && state != ST_FAULTED;
  assign int_fault = cmd_fault || seq_fault || rst_fault;
  assign fault_now = int_fault || ext_fault;

  // Sequencing state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      pos <= POS_FIRST;
      dly_active <= 1'b0;
      waiting <= 1'b0;
      first_step <= 1'b0;
    end else if (fault_now) begin
      state <= ST_FAULTED;
      dly_active <= 1'b0;
      waiting <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (req_rise) begin
            state <= ST_SEQ_UP;
            pos <= POS_FIRST;
            dly_active <= 1'b1;
            first_step <= 1'b1;
          end
        end
        ST_SEQ_UP: begin
          if (delay_done) begin
            dly_active <= 1'b0;
            waiting <= 1'b1;
            first_step <= 1'b0;
          end else if (waiting && &(~at_pos | sense.up_above)) begin
            waiting <= 1'b0;
            if (pos == POS_LAST) begin
              state <= ST_MONITOR;
            end else begin
              pos <= POS_W'(pos + 1'b1);
              dly_active <= 1'b1;
            end
          end
        end
        ST_MONITOR: begin
          if (req_fall) begin
            state <= ST_SEQ_DOWN;
            pos <= POS_LAST;
            dly_active <= 1'b1;
            first_step <= 1'b1;
          end
        end
        ST_SEQ_DOWN: begin
          if (delay_done) begin
            dly_active <= 1'b0;
            waiting <= 1'b1;
            first_step <= 1'b0;
          end else if (waiting && &(~at_pos | sense.down_below)) begin
            waiting <= 1'b0;
            if (pos == POS_FIRST) begin
              state <= ST_IDLE;
            end else begin
              pos <= POS_W'(pos - 1'b1);
              dly_active <= 1'b1;
            end
          end
        end
        ST_FAULTED: begin
          if (!sense.seq_request && &sense.down_below) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_enable <= '0;
    end else if ((fault_now || state == ST_FAULTED) && !cfg.debug) begin
      supply_enable <= '0;
    end else if (state == ST_SEQ_UP && delay_done) begin
      supply_enable <= supply_enable | at_pos;
    end else if (state == ST_SEQ_DOWN && delay_done) begin
      supply_enable <= supply_enable & ~at_pos;
    end
  end

  // Power-good watchdog runs from the first enable edge of a phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_active <= 1'b0;
    end else if (!in_seq || fault_now ||
                 (state == ST_SEQ_UP && waiting && pos == POS_LAST) ||
                 (state == ST_SEQ_DOWN && waiting && pos == POS_FIRST)) begin
      pg_active <= 1'b0;
    end else if (delay_done && |at_pos) begin
      pg_active <= 1'b1;
    end
  end

  // Flags
  always_comb begin
    next_flags = channel_compare_flag;
    if (fault_now) begin
      case (1'b1)
        cmd_fault: next_flags = FC_CMD;
        seq_fault: next_flags = ~(at_pos & ~(state == ST_SEQ_UP ?
          sense.up_above : sense.down_below));
        rst_fault: next_flags = ~sense.uv_below;
        default: next_flags = FC_EXT;
      endcase
    end else if (state == ST_FAULTED) begin
      next_flags = channel_compare_flag;
    end else if (in_seq) begin
      next_flags = '0;
    end else if (state == ST_MONITOR) begin
      next_flags = ~sense.uv_below;
    end else begin
      next_flags = FLAGS_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_compare_flag <= FLAGS_IDLE;
      ftype <= FT_NONE;
    end else begin
      channel_compare_flag <= next_flags;
      if (fault_now) begin
        ftype <= cmd_fault ? FT_CMD : seq_fault ? FT_SEQ :
          rst_fault ? FT_RST : FT_EXT;
      end else if (state != ST_FAULTED) begin
        ftype <= FT_NONE;
      end
    end
  end

  // Open-drain lines, cascade drive and reset output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_line_n_out <= 1'b0;
      fault_line_n_oe <= 1'b0;
      done_n_out <= 1'b0;
      done_n_oe <= 1'b0;
      cascade_out <= 1'b0;
      cascade_oe <= 1'b0;
    end else begin
      fault_line_n_out <= 1'b0;
      done_n_out <= 1'b0;
      if (int_fault) begin
        fault_line_n_oe <= 1'b1;
      end else if (state != ST_FAULTED) begin
        fault_line_n_oe <= 1'b0;
      end
      if (state == ST_SEQ_UP && waiting && pos == POS_LAST &&
          &(~at_pos | sense.up_above) && !fault_now) begin
        done_n_oe <= 1'b1;
      end else if (state == ST_IDLE) begin
        done_n_oe <= 1'b0;
      end
      cascade_out <= cfg.master && dly_active && !delay_done;
      cascade_oe <= cfg.master && dly_active && !delay_done;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_out_n <= 1'b0;
      rst_released <= 1'b0;
    end else begin
      if (!all_good) begin
        reset_out_n <= 1'b0;
      end else if (rst_exp) begin
        reset_out_n <= 1'b1;
      end
      if (state == ST_IDLE) begin
        rst_released <= 1'b0;
      end else if (reset_out_n) begin
        rst_released <= 1'b1;
      end
    end
  end

  // APB slave, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= CTRL_RESET;
      time_position_select <= TPOS_RESET;
      seq_dly <= SEQ_DLY_CYC;
      pg_lim <= PG_LIM_CYC;
      rst_dly <= RST_DLY_CYC;
    end else if (psel && penable && pwrite && pready) begin
      case (paddr)
        OFF_CTRL: cfg <= pwdata[CTRL_W-1:0];
        OFF_TPOS: time_position_select <= pwdata[TPOS_W-1:0];
        OFF_SEQ_DLY: seq_dly <= pwdata[CNT_W-1:0];
        OFF_PG_LIM: pg_lim <= pwdata[CNT_W-1:0];
        OFF_RST_DLY: rst_dly <= pwdata[CNT_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Read data is latched in setup so it stands through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (psel && !penable) begin
        pslverr <= !mapped(paddr);
        prdata <= '0;
        case (paddr)
          OFF_CTRL: prdata[CTRL_W-1:0] <= cfg;
          OFF_TPOS: prdata[TPOS_W-1:0] <= time_position_select;
          OFF_SEQ_DLY: prdata[CNT_W-1:0] <= seq_dly;
          OFF_PG_LIM: prdata[CNT_W-1:0] <= pg_lim;
          OFF_RST_DLY: prdata[CNT_W-1:0] <= rst_dly;
          OFF_STATUS: begin
            prdata[ST_STATE +: 3] <= state;
            prdata[ST_FAULT] <= state == ST_FAULTED;
            prdata[ST_DONE] <= done_n_oe;
            prdata[ST_RST] <= reset_out_n;
            prdata[ST_EN +: NCH] <= supply_enable;
            prdata[ST_POS +: POS_W] <= pos;
            prdata[ST_FTYPE +: 3] <= ftype;
          end
          OFF_FLAGS: prdata[NCH-1:0] <= channel_compare_flag;
          default: begin
          end
        endcase
      end
    end
  end

  a_seq_start: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_IDLE && req_rise && !fault_now |=> state == ST_SEQ_UP)
    else $error("sequence-up did not start");
  a_seq_down: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_MONITOR && req_fall && !fault_now |=> state == ST_SEQ_DOWN)
    else $error("sequence-down did not start");
  a_cmd_fault: assert property (@(posedge pclk) disable iff (!presetn)
    in_seq && (req_rise || req_fall) |=> state == ST_FAULTED && ftype == FT_CMD)
    else $error("command fault missed");
  a_flags_seq: assert property (@(posedge pclk) disable iff (!presetn)
    in_seq && !fault_now |=> channel_compare_flag == '0)
    else $error("flags not low in sequencing");
  a_flags_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_FAULTED ##1 state == ST_FAULTED |-> $stable(channel_compare_flag))
    else $error("flags moved during fault");
  a_done_set: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_SEQ_UP ##1 state == ST_MONITOR |-> done_n_oe && !done_n_out)
    else $error("done not driven after sequence-up");
  a_done_release: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_SEQ_DOWN ##1 state == ST_IDLE |=> !done_n_oe)
    else $error("done not released after sequence-down");
  a_fault_drive: assert property (@(posedge pclk) disable iff (!presetn)
    int_fault |=> fault_line_n_oe && !fault_line_n_out ##1 fault_line_n_oe)
    else $error("fault line not pulled");
  a_fault_enables: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_FAULTED && !cfg.debug |-> supply_enable == '0)
    else $error("enables on during fault");
  a_rtz_clear: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_FAULTED && !sense.seq_request && &sense.down_below
    |=> state == ST_IDLE)
    else $error("fault not cleared at return to zero");
  a_rst_low: assert property (@(posedge pclk) disable iff (!presetn)
    |sense.uv_below |=> !reset_out_n)
    else $error("reset not low on undervoltage");
endmodule

// *** logic/sps_pkg.sv ***
package sps_pkg;
  localparam int NCH = 4;
  localparam int POS_W = 3;
  localparam int CNT_W = 28;
  localparam int TPOS_W = NCH * POS_W;
  localparam logic [POS_W-1:0] POS_FIRST = 3'h0;
  localparam logic [POS_W-1:0] POS_LAST = 3'h7;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TPOS = 8'h04;
  localparam logic [7:0] OFF_SEQ_DLY = 8'h08;
  localparam logic [7:0] OFF_PG_LIM = 8'h0c;
  localparam logic [7:0] OFF_RST_DLY = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_FLAGS = 8'h18;

  // Control fields and reset values
  localparam int CTRL_MASTER = 0;
  localparam int CTRL_FIRST = 1;
  localparam int CTRL_RST_FLT = 2;
  localparam int CTRL_DEBUG = 3;
  localparam int CTRL_W = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h3;
  localparam logic [TPOS_W-1:0] TPOS_RESET = 12'h688;

  // Status fields
  localparam int ST_STATE = 0;
  localparam int ST_FAULT = 3;
  localparam int ST_DONE = 4;
  localparam int ST_RST = 5;
  localparam int ST_EN = 8;
  localparam int ST_POS = 12;
  localparam int ST_FTYPE = 16;

  // Timer defaults, as times, then cycles at the bus clock
  localparam int CLK_MHZ = 100;
  localparam int SEQ_DLY_US = 100;
  localparam int RST_DLY_US = 50;
  localparam int PG_LIM_MS = 400;
  localparam int SEQ_DLY_DEF = SEQ_DLY_US * CLK_MHZ;
  localparam int RST_DLY_DEF = RST_DLY_US * CLK_MHZ;
  localparam int PG_LIM_DEF = PG_LIM_MS * 1000 * CLK_MHZ;

  // Flag patterns latched on faults without a channel source, and the idle pattern
  localparam logic [NCH-1:0] FC_CMD = 4'ha;
  localparam logic [NCH-1:0] FC_EXT = 4'h5;
  localparam logic [NCH-1:0] FLAGS_IDLE = 4'hf;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SEQ_UP = 3'b001,
    ST_MONITOR = 3'b011,
    ST_SEQ_DOWN = 3'b010,
    ST_FAULTED = 3'b110
  } sps_state_type;

  typedef enum logic [2:0] {
    FT_NONE = 3'h0,
    FT_CMD = 3'h1,
    FT_SEQ = 3'h2,
    FT_EXT = 3'h3,
    FT_RST = 3'h4
  } sps_ftype_type;

  typedef struct packed {
    logic debug;
    logic rst_fault;
    logic first;
    logic master;
  } sps_cfg_type;

  typedef struct packed {
    logic seq_request;
    logic fault_line_n;
    logic cascade;
    logic [NCH-1:0] uv_below;
    logic [NCH-1:0] up_above;
    logic [NCH-1:0] down_below;
  } sps_sense_type;
  localparam int SENSE_W = 3 + 3 * NCH;
endpackage

// *** logic/sps_sync.sv ***
module sps_sync
  import sps_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] stage;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage <= '0;
      q <= '0;
    end else begin
      stage <= d;
      q <= stage;
    end
  end
endmodule

// *** logic/sps_timer.sv ***
module sps_timer
  import sps_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic clear,
  input wire logic run,
  input wire logic [CNT_W-1:0] limit,
  output logic expired
);
  logic [CNT_W-1:0] count;

  // Stops at the limit so it cannot wrap back below it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (run && !expired) begin
      count <= CNT_W'(count + 1'b1);
    end
  end

  assign expired = run && (count >= limit);
endmodule

// *** sim/sps_supply_model.sv ***
module sps_supply_model
  import sps_pkg::*;
#(
  parameter int RAMP = 6
) (
  // Clock
  input wire logic pclk,
  // Scenario controls
  input wire logic slow,
  input wire logic [NCH-1:0] late_mask,
  input wire logic [NCH-1:0] uv_force,
  input wire logic ext_pull,
  // Device side
  input wire logic [NCH-1:0] supply_enable,
  input wire logic fault_line_n_oe,
  input wire logic cascade_out,
  input wire logic cascade_oe,
  output logic [NCH-1:0] uv_below,
  output logic [NCH-1:0] up_above,
  output logic [NCH-1:0] down_below,
  output logic fault_line_n_in,
  output logic cascade_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int lvl [NCH];
  logic tick = 1'b0;

  // Supplies ramp in steps; a late channel never reaches its threshold
  always @(posedge pclk) begin
    tick <= slow ? ~tick : 1'b1;
    for (int i = 0; i < NCH; i++) begin
      if (tick && supply_enable[i] && !late_mask[i] && lvl[i] < RAMP)
        lvl[i] <= lvl[i] + 1;
      else if (tick && !supply_enable[i] && lvl[i] > 0)
        lvl[i] <= lvl[i] - 1;
    end
  end

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      up_above[i] = (lvl[i] == RAMP);
      down_below[i] = (lvl[i] == 0);
      uv_below[i] = (lvl[i] < RAMP) || uv_force[i];
    end
  end

  // Pulled-up shared line, any party may pull it low
  assign fault_line_n_in = !(fault_line_n_oe || ext_pull);
  // Weak pull-down when no master drives the cascade line
  assign cascade_in = cascade_oe ? cascade_out : 1'b0;
endmodule

// *** sim/supply_sequencer_fault_control_tb.sv ***
module supply_sequencer_fault_control_tb
  import sps_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, reset_out_n, fault_line_n_in, fault_line_n_out;
  logic fault_line_n_oe, done_n_out, done_n_oe;
  logic cascade_in, cascade_out, cascade_oe;
  logic seq_request = 1'b0;
  logic slow = 1'b0;
  logic ext_pull = 1'b0;
  logic [NCH-1:0] late_mask = 4'h0;
  logic [NCH-1:0] uv_force = 4'h0;
  logic [NCH-1:0] uv_below, up_above, down_below;
  logic [NCH-1:0] supply_enable, channel_compare_flag, en_q;
  logic [TPOS_W-1:0] tp = TPOS_RESET;
  logic [31:0] d;
  logic e;
  bit up_ph, dn_ph, cas_seen;
  int error_cnt = 0;
  int n_compared = 0;
  int seed = 32'h3c42_be98;

  always #5 pclk = ~pclk;

  sps_sequencer #(.SEQ_DLY_CYC(CNT_W'(8)), .PG_LIM_CYC(CNT_W'(200)),
    .RST_DLY_CYC(CNT_W'(8))) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .seq_request(seq_request), .uv_below(uv_below), .up_above(up_above),
    .down_below(down_below), .supply_enable(supply_enable),
    .channel_compare_flag(channel_compare_flag), .reset_out_n(reset_out_n),
    .fault_line_n_in(fault_line_n_in), .fault_line_n_out(fault_line_n_out),
    .fault_line_n_oe(fault_line_n_oe), .done_n_out(done_n_out),
    .done_n_oe(done_n_oe), .cascade_in(cascade_in),
    .cascade_out(cascade_out), .cascade_oe(cascade_oe));

  sps_supply_model model (.pclk(pclk), .slow(slow), .late_mask(late_mask),
    .uv_force(uv_force), .ext_pull(ext_pull), .supply_enable(supply_enable),
    .fault_line_n_oe(fault_line_n_oe), .cascade_out(cascade_out),
    .cascade_oe(cascade_oe), .uv_below(uv_below), .up_above(up_above),
    .down_below(down_below), .fault_line_n_in(fault_line_n_in),
    .cascade_in(cascade_in));

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Entered just after a rising edge; one idle edge follows the release
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd, output logic err);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (!(pready === 1'b1) && n < 50);
    if (n >= 50) begin
      check("pready", 0, 1);
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic cond(int k);
    case (k)
      0: return done_n_oe;
      1: return fault_line_n_oe;
      2: return reset_out_n;
      3: return supply_enable == 4'h0;
      default: return channel_compare_flag == FLAGS_IDLE;
    endcase
  endfunction

  task automatic wait_on(input int k, input logic v);
    int n;
    n = 0;
    while (cond(k) !== v && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 3000) begin
      check($sformatf("wait %0d", k), 0, 1);
      report_and_stop();
    end
  endtask

  function automatic logic [NCH-1:0] chans(logic [TPOS_W-1:0] t, int p,
    bit incl);
    logic [NCH-1:0] m;
    for (int i = 0; i < NCH; i++)
      m[i] = incl ? (t[POS_W*i +: POS_W] <= p) : (t[POS_W*i +: POS_W] < p);
    return m;
  endfunction

  // Enables change only at their positions, flags low at each enable change while sequencing
  always @(posedge pclk) begin
    en_q <= supply_enable;
    if (cascade_oe === 1'b1)
      cas_seen <= 1'b1;
    if (cascade_oe === 1'b1)
      check("cas out", cascade_out, 1);
    if ((up_ph || dn_ph) && supply_enable !== en_q)
      check("flags seq", channel_compare_flag, 4'h0);
    for (int i = 0; i < NCH; i++) begin
      if (up_ph && supply_enable[i] && !en_q[i])
        check("en up", supply_enable, chans(tp, tp[POS_W*i +: POS_W], 1));
      if (dn_ph && !supply_enable[i] && en_q[i])
        check("en down", supply_enable, chans(tp, tp[POS_W*i +: POS_W], 0));
    end
  end

  task automatic power_up();
    seq_request <= 1'b1;
    wait_on(0, 1'b1);
  endtask

  task automatic to_idle();
    seq_request <= 1'b0;
    wait_on(4, 1'b1);
    check("fault oe idle", fault_line_n_oe, 0);
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, OFF_CTRL, 0, d, e);
    check("ctrl reset", d, 32'h0000_0003);
    apb(0, OFF_TPOS, 0, d, e);
    check("tpos reset", d, 32'h0000_0688);
    apb(0, 8'h40, 0, d, e);
    check("unmapped err", e, 1);
    check("unmapped data", d, 0);
    check("flags idle", channel_compare_flag, FLAGS_IDLE);
    $display("test reset done");
    for (int r = 0; r < 3; r++) begin
      tp = (r == 0) ? 12'hfff : TPOS_W'($random(seed));
      slow <= 1'($random(seed));
      apb(1, OFF_TPOS, 32'(tp), d, e);
      up_ph = 1;
      power_up();
      up_ph = 0;
      check("en all", supply_enable, 4'hf);
      check("cascade", cas_seen, 1);
      apb(0, OFF_STATUS, 0, d, e);
      check("state mon", d[2:0], 3'b011);
      wait_on(2, 1'b1);
      uv_force <= 4'h1 << r;
      repeat (6) @(posedge pclk);
      check("flags uv", channel_compare_flag, NCH'(~(4'h1 << r)));
      check("reset low", reset_out_n, 0);
      uv_force <= 4'h0;
      wait_on(2, 1'b1);
      dn_ph = 1;
      seq_request <= 1'b0;
      wait_on(0, 1'b0);
      dn_ph = 0;
      check("en off", supply_enable, 4'h0);
      $display("test cycle %0d done", r);
    end
    seq_request <= 1'b1;
    repeat (6) @(posedge pclk);
    seq_request <= 1'b0;
    wait_on(1, 1'b1);
    check("flags cmd", channel_compare_flag, FC_CMD);
    check("en cmd", supply_enable, 4'h0);
    apb(0, OFF_STATUS, 0, d, e);
    check("ftype cmd", d[18:16], FT_CMD);
    to_idle();
    $display("test command fault done");
    power_up();
    ext_pull <= 1'b1;
    repeat (4) @(posedge pclk);
    ext_pull <= 1'b0;
    wait_on(3, 1'b1);
    check("flags ext", channel_compare_flag, FC_EXT);
    check("ext not driven", fault_line_n_oe, 0);
    repeat (30) @(posedge pclk);
    apb(0, OFF_STATUS, 0, d, e);
    check("fault held", d[ST_FAULT], 1);
    to_idle();
    $display("test external fault done");
    tp = TPOS_RESET;
    apb(1, OFF_TPOS, 32'(tp), d, e);
    late_mask <= 4'h1;
    seq_request <= 1'b1;
    wait_on(1, 1'b1);
    check("flags late", channel_compare_flag, 4'he);
    late_mask <= 4'h0;
    to_idle();
    $display("test late supply done");
    apb(1, OFF_CTRL, 32'h0000_0007, d, e);
    power_up();
    wait_on(2, 1'b1);
    uv_force <= 4'h2;
    wait_on(1, 1'b1);
    check("flags rst", channel_compare_flag, 4'hd);
    check("en rst", supply_enable, 4'h0);
    apb(0, OFF_STATUS, 0, d, e);
    check("ftype rst", d[18:16], FT_RST);
    uv_force <= 4'h0;
    to_idle();
    $display("test reset fault done");
    apb(1, OFF_CTRL, 32'h0000_000b, d, e);
    power_up();
    ext_pull <= 1'b1;
    repeat (8) @(posedge pclk);
    check("en debug", supply_enable, 4'hf);
    $display("test debug done");
    report_and_stop();
  end
endmodule
